/* File: design/rtc_control.sv */
// Control, status and interrupt registers of the clock, on a muxed bus.
// Assumes bus pins are synchronous to clk_sys; time bytes come from outside.
`timescale 1ns/1ps
module rtc_control
   import rtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic por_n,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic addr_strobe,
   input wire logic data_strobe,
   input wire logic read_not_write,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe,
   output logic interrupt_request_n,
   output logic square_wave_out,
   input wire logic battery_good,
   input wire rtc_hms_s time_now,
   input wire rtc_hms_s alarm_time,
   output logic count_advance,
   output logic user_freeze,
   output logic binary_format_select,
   output logic hour_format_select,
   output logic daylight_saving_enable
);
   logic rst_all_n;
   rtc_bus_e bus_state;
   logic [6:0] addr;
   logic [7:0] wr_data;
   logic [2:0] dv;
   logic [3:0] rs;
   logic periodic_irq_enable;
   logic alarm_irq_enable;
   logic update_done_irq_enable;
   logic square_wave_enable;
   logic battery_valid_flag;
   rtc_flags_s flags;
   rtc_flags_s pend;
   rtc_flags_s ev;
   logic any_irq;
   logic rd_start;
   logic rd_end;
   logic wr_commit;
   logic wr_rate;
   logic wr_mode;
   logic hit;
   logic preset;
   logic tap_level;
   logic tap_edge;
   logic uip_w;
   logic update;
   logic alarm_ev;
   logic [7:0] rd_mux;
   logic freeze_q;

   function automatic logic byte_match(input logic [7:0] al, input logic [7:0] tm);
      return (al[7:6] == ALARM_ANY) || (al == tm);
   endfunction

   assign rst_all_n = por_n & rst_n;
   assign rd_start = (bus_state == BUS_IDLE) && data_strobe && !chip_select_n && read_not_write;
   assign rd_end = (bus_state == BUS_READ) && !data_strobe;
   assign wr_commit = (bus_state == BUS_WRITE) && !data_strobe;
   assign wr_rate = wr_commit && (addr == ADDR_RATE);
   assign wr_mode = wr_commit && (addr == ADDR_MODE);
   assign hit = (addr >= ADDR_RATE) && (addr <= ADDR_VALID);
   assign preset = wr_rate && (wr_data[RATE_DV_LSB+:3] == DV_RUN) && (dv != DV_RUN);
   assign alarm_ev = update && byte_match(alarm_time.sec, time_now.sec)
      && byte_match(alarm_time.min, time_now.min)
      && byte_match(alarm_time.hr, time_now.hr);
   assign ev = '{pf: tap_edge, af: alarm_ev, uf: update};
   assign any_irq = (flags.pf && periodic_irq_enable) || (flags.af && alarm_irq_enable) || (flags.uf && update_done_irq_enable);
   assign user_freeze = freeze_q;

   rtc_divider u_div (
      .clk_sys(clk_sys),
      .por_n(por_n),
      .dv(dv),
      .rs(rs),
      .freeze(freeze_q),
      .preset(preset),
      .tap_level(tap_level),
      .tap_edge(tap_edge),
      .update_pending_flag(uip_w),
      .update(update)
   );

   // Read view of the four registers
   always_comb begin
      rd_mux = 8'h00;
      unique case (addr)
         ADDR_RATE: rd_mux = {uip_w, dv, rs};
         ADDR_MODE: rd_mux = {freeze_q, periodic_irq_enable, alarm_irq_enable, update_done_irq_enable, square_wave_enable, binary_format_select,
            hour_format_select, daylight_saving_enable};
         ADDR_FLAGS: rd_mux = {any_irq, flags, 4'h0};
         ADDR_VALID: rd_mux = {battery_valid_flag, 7'h00};
         default: rd_mux = 8'h00;
      endcase
   end

   // Bus sequencing: address on strobe, read data latched at strobe rise
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         bus_state <= BUS_IDLE;
         addr <= 7'h00;
         wr_data <= 8'h00;
      end else begin
         if (addr_strobe) begin
            addr <= ad_in[6:0];
         end
         if (data_strobe) begin
            wr_data <= ad_in;
         end
         unique case (bus_state)
            BUS_IDLE: begin
               if (data_strobe && !chip_select_n) begin
                  bus_state <= read_not_write ? BUS_READ : BUS_WRITE;
               end
            end
            BUS_READ: begin
               if (!data_strobe) begin
                  bus_state <= BUS_IDLE;
               end
            end
            BUS_WRITE: begin
               if (!data_strobe) begin
                  bus_state <= BUS_IDLE;
               end
            end
            default: bus_state <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         ad_out <= 8'h00;
         ad_oe <= 1'b0;
      end else if (rd_start) begin
         ad_out <= rd_mux;
         ad_oe <= hit;
      end else if (rd_end) begin
         ad_oe <= 1'b0;
      end
   end

   // Bits kept through the reset pin
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         dv <= DV_POR;
         rs <= RS_POR;
         freeze_q <= 1'b0;
         binary_format_select <= 1'b0;
         hour_format_select <= 1'b0;
         daylight_saving_enable <= 1'b0;
      end else begin
         if (wr_rate) begin
            dv <= wr_data[RATE_DV_LSB+:3];
            rs <= wr_data[3:0];
         end
         if (wr_mode) begin
            freeze_q <= wr_data[MODE_FREEZE_BIT];
            binary_format_select <= wr_data[MODE_BIN_BIT];
            hour_format_select <= wr_data[MODE_HR24_BIT];
            daylight_saving_enable <= wr_data[MODE_DSE_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         battery_valid_flag <= 1'b0;
         count_advance <= 1'b0;
      end else begin
         battery_valid_flag <= battery_good;
         count_advance <= update;
      end
   end

   // Enables cleared by the reset pin
   always_ff @(posedge clk_sys or negedge rst_all_n) begin
      if (!rst_all_n) begin
         periodic_irq_enable <= 1'b0;
         alarm_irq_enable <= 1'b0;
         update_done_irq_enable <= 1'b0;
         square_wave_enable <= 1'b0;
      end else if (wr_mode) begin
         periodic_irq_enable <= wr_data[MODE_PIE_BIT];
         alarm_irq_enable <= wr_data[MODE_AIE_BIT];
         square_wave_enable <= wr_data[MODE_SQUARE_WAVE_ENABLE_BIT];
         update_done_irq_enable <= wr_data[MODE_UIE_BIT] && !(wr_data[MODE_FREEZE_BIT] && !freeze_q);
      end
   end

   // Flags: frozen during a flag read, late events held then posted
   always_ff @(posedge clk_sys or negedge rst_all_n) begin
      if (!rst_all_n) begin
         flags <= '0;
         pend <= '0;
      end else if (rd_end && (addr == ADDR_FLAGS)) begin
         flags <= pend | ev;
         pend <= '0;
      end else if ((rd_start || (bus_state == BUS_READ)) && (addr == ADDR_FLAGS)) begin
         pend <= pend | ev;
      end else begin
         flags <= flags | ev;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_all_n) begin
      if (!rst_all_n) begin
         interrupt_request_n <= 1'b1;
         square_wave_out <= 1'b0;
      end else begin
         interrupt_request_n <= !any_irq;
         square_wave_out <= square_wave_enable && tap_level;
      end
   end

   irq_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      any_irq |=> !interrupt_request_n) else $error("enabled flag did not pull pin low");
   irq_release_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      !any_irq |=> interrupt_request_n) else $error("pin low with no enabled flag");
   late_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (flags.pf && $rose(periodic_irq_enable)) |=> !interrupt_request_n)
      else $error("enabling set flag did not assert pin");
   sqw_held_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      !square_wave_enable |=> !square_wave_out) else $error("square wave not low when disabled");
   freeze_uip_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      freeze_q |=> !uip_w) else $error("pending bit high while frozen");
   uip_lead_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      count_advance |-> $past(uip_w, 2)) else $error("transfer without pending bit");
   uie_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      $rose(freeze_q) |-> !update_done_irq_enable) else $error("update enable kept on freeze rise");
   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (rd_end && addr == ADDR_FLAGS && pend == '0 && ev == '0) |=> flags == '0)
      else $error("flag read did not clear flags");
   flag_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (bus_state == BUS_READ && addr == ADDR_FLAGS && !rd_end) |=> $stable(flags))
      else $error("flags moved during read");
   pf_set_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (tap_edge && bus_state == BUS_IDLE && !(rd_start && addr == ADDR_FLAGS)) |=> flags.pf)
      else $error("periodic flag not set");
   low_nibble_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      (ad_oe && addr == ADDR_FLAGS) |-> ad_out[3:0] == 4'h0)
      else $error("flag low nibble not zero");
   valid_low_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      (ad_oe && addr == ADDR_VALID) |-> ad_out[6:0] == 7'h00)
      else $error("validity low bits not zero");
   rate_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_rate |=> $stable(rs)) else $error("rate field changed without write");
   read_snap_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      rd_start |=> ad_out == $past(rd_mux))
      else $error("read data not latched at strobe");
   flag_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (bus_state == BUS_READ && addr == ADDR_FLAGS && !rd_end && ev.pf) |=> pend.pf)
      else $error("event during flag read not held");
   flag_post_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (rd_end && addr == ADDR_FLAGS && pend.pf) |=> flags.pf)
      else $error("held event not posted after read");
   any_irq_flag_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      ($rose(ad_oe) && addr == ADDR_FLAGS) |-> ad_out[7] == ((ad_out[6] && periodic_irq_enable)
      || (ad_out[5] && alarm_irq_enable) || (ad_out[4] && update_done_irq_enable))) else $error("summary bit wrong");
   dv_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_rate |=> $stable(dv))
      else $error("divider field changed without write");
   freeze_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_mode |=> $stable(freeze_q))
      else $error("freeze bit changed without write");
   format_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_mode |=> $stable(binary_format_select))
      else $error("format bit changed without write");
   hour_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_mode |=> $stable(hour_format_select))
      else $error("hour format bit changed without write");
   dst_keep_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      !wr_mode |=> $stable(daylight_saving_enable))
      else $error("daylight bit changed without write");
   pie_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      !wr_mode |=> $stable(periodic_irq_enable))
      else $error("periodic enable changed without write");
   aie_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      !wr_mode |=> $stable(alarm_irq_enable))
      else $error("alarm enable changed without write");
   update_block_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      freeze_q |=> !update)
      else $error("transfer while frozen");
   hold_uip_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      (dv != DV_RUN) |=> !uip_w)
      else $error("pending bit high with chain stopped");
   osc_tap_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      (dv != DV_RUN) |-> !tap_level)
      else $error("tap active with chain stopped");
   rate_off_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      (rs == 4'h0) |-> !tap_level)
      else $error("tap active with rate off");
   sqw_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      square_wave_enable |=> square_wave_out == $past(tap_level))
      else $error("square wave does not follow tap");
   count_pulse_a: assert property (@(posedge clk_sys) disable iff (!por_n)
      count_advance |=> !count_advance)
      else $error("advance pulse longer than one cycle");
   uie_write_a: assert property (@(posedge clk_sys) disable iff (!rst_all_n)
      (wr_mode && freeze_q) |=> update_done_irq_enable == $past(wr_data[MODE_UIE_BIT]))
      else $error("update enable not written");
endmodule

/* File: design/rtc_divider.sv */
// Oscillator tick generator, 15-stage up-counting chain and tap selector.
// Assumes control inputs come from registers in the same clock domain.
`timescale 1ns/1ps
module rtc_divider
   import rtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic por_n,
   input wire logic [2:0] dv,
   input wire logic [3:0] rs,
   input wire logic freeze,
   input wire logic preset,
   output logic tap_level,
   output logic tap_edge,
   output logic update_pending_flag,
   output logic update
);
   logic [ACC_W-1:0] acc;
   logic tick;
   logic [CHAIN_W-1:0] chain;
   logic tap_q;
   logic osc_on;
   logic chain_hold;
   logic run;
   logic wrap;
   logic [4:0] tap_sel;

   function automatic logic [4:0] tap_index(input logic [3:0] r);
      logic [4:0] t;
      t = 5'h00;
      if (r == 4'h1) begin
         t = 5'h16;
      end else if (r == 4'h2) begin
         t = 5'h17;
      end else if (r != 4'h0) begin
         t = {1'b1, r - 4'h2};
      end
      return t;
   endfunction

   assign osc_on = (dv == DV_RUN) || (dv[2:1] == DV_HOLD_TOP);
   assign chain_hold = (dv[2:1] == DV_HOLD_TOP);
   assign run = (dv == DV_RUN);
   assign wrap = tick && run && (chain == {CHAIN_W{1'b1}});
   assign tap_sel = tap_index(rs);
   assign tap_level = tap_sel[4] && run && chain[tap_sel[3:0]];
   assign tap_edge = tap_level && !tap_q;

   // Fractional accumulator, 32768 ticks per second
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         acc <= '0;
         tick <= 1'b0;
      end else if (!osc_on) begin
         acc <= '0;
         tick <= 1'b0;
      end else if (acc >= ACC_LIMIT) begin
         acc <= acc - ACC_LIMIT;
         tick <= 1'b1;
      end else begin
         acc <= acc + OSC_STEP;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         chain <= '0;
      end else if (chain_hold) begin
         chain <= '0;
      end else if (preset) begin
         chain <= CHAIN_PRESET;
      end else if (tick && run) begin
         chain <= chain + 1'b1;
      end
   end

   // Pending bit leads the transfer; a transfer needs it already high
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         update_pending_flag <= 1'b0;
         update <= 1'b0;
         tap_q <= 1'b0;
      end else begin
         update_pending_flag <= !freeze && run && (chain >= UIP_START);
         update <= wrap && update_pending_flag && !freeze;
         tap_q <= tap_level;
      end
   end
endmodule

/* File: shared/rtc_pkg.sv */
// Constants, field layouts and carrier types for the clock control block.
// Assumes a 20 MHz system clock and a host on a multiplexed address/data bus.
// How it works
// - Low update-pending bit promises 244 us quiet.
// - Freeze blocks transfers and forces pending low.
// - Divider field: 010 runs, 11X holds, else off.
// - First update 500 ms after writing 010 from off, 1 s after writing it from 11X.
// - Rate field picks one of 13 taps.
// - Rate field survives the reset pin.
// - Unfrozen counts advance each second; freeze survives reset.
// - Periodic enable gates pin; reset clears it.
// - Alarm matches time, 11 top bits match any.
// - Update enable cleared by reset or freeze rising.
// - Square wave toggles when enabled, else low.
// - Binary format bit read/write, drives binary_format_select, survives reset.
// - Hour format bit read/write, survives reset.
// - Daylight saving bit survives reset, drives jumps.
// - Summary bit is OR of enabled flags; drives pin.
// - Flag read or reset clears all flags.
// - Periodic flag sets on tap edge regardless.
// - Alarm flag on match, update flag per update.
// - Flag register low nibble reads zero.
// - Validity bit read-only, low bits read zero.
// - Flags held stable during read, late ones posted.
// - Enabling an already set flag asserts pin at once.
// - Pending bit rises 244 us before each transfer.
package rtc_pkg;
   localparam logic [6:0] ADDR_RATE = 7'h0a;
   localparam logic [6:0] ADDR_MODE = 7'h0b;
   localparam logic [6:0] ADDR_FLAGS = 7'h0c;
   localparam logic [6:0] ADDR_VALID = 7'h0d;
   localparam int RATE_UIP_BIT = 7;
   localparam int RATE_DV_LSB = 4;
   localparam int MODE_FREEZE_BIT = 7;
   localparam int MODE_PIE_BIT = 6;
   localparam int MODE_AIE_BIT = 5;
   localparam int MODE_UIE_BIT = 4;
   localparam int MODE_SQUARE_WAVE_ENABLE_BIT = 3;
   localparam int MODE_BIN_BIT = 2;
   localparam int MODE_HR24_BIT = 1;
   localparam int MODE_DSE_BIT = 0;
   localparam logic [2:0] DV_RUN = 3'h2;
   localparam logic [1:0] DV_HOLD_TOP = 2'h3;
   localparam logic [2:0] DV_POR = 3'h0;
   localparam logic [3:0] RS_POR = 4'h0;
   localparam logic [1:0] ALARM_ANY = 2'h3;
   localparam int CLK_HZ = 20000000;
   localparam int OSC_HZ = 32768;
   localparam int ACC_W = 25;
   localparam int CHAIN_W = 15;
   localparam logic [ACC_W-1:0] OSC_STEP = ACC_W'(OSC_HZ);
   localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(CLK_HZ - OSC_HZ);
   localparam int UIP_LEAD_US = 244;
   localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
   localparam int FIRST_UPDATE_MS = 500;
   localparam int FIRST_UPDATE_TICKS = FIRST_UPDATE_MS * OSC_HZ / 1000;
   localparam logic [CHAIN_W-1:0] CHAIN_PRESET = CHAIN_W'((1 << CHAIN_W) - FIRST_UPDATE_TICKS);
   localparam logic [CHAIN_W-1:0] UIP_START = CHAIN_W'((1 << CHAIN_W) - UIP_LEAD_TICKS);

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_READ = 2'b01,
      BUS_WRITE = 2'b10
   } rtc_bus_e;

   typedef struct packed {
      logic [7:0] hr;
      logic [7:0] min;
      logic [7:0] sec;
   } rtc_hms_s;

   typedef struct packed {
      logic pf;
      logic af;
      logic uf;
   } rtc_flags_s;
endpackage

/* File: tb/rtc_host.sv */
// Host processor model driving the multiplexed strobe bus of the clock block.
// Assumes the bench calls access one at a time; released data lines invert.
`timescale 1ns/1ps
module rtc_host (
   input wire logic clk_sys,
   output logic chip_select_n,
   output logic addr_strobe,
   output logic data_strobe,
   output logic read_not_write,
   output logic [7:0] ad_in,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe
);
   logic [7:0] rd_data;
   logic rd_oe;

   initial begin
      chip_select_n = 1'b1;
      addr_strobe = 1'b0;
      data_strobe = 1'b0;
      read_not_write = 1'b1;
      ad_in = 8'h00;
      rd_data = 8'h00;
      rd_oe = 1'b0;
   end

   // Address pulse, data pulse held three edges, then two idle edges
   task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] wd);
      @(posedge clk_sys);
      addr_strobe <= 1'b1;
      ad_in <= {1'b0, a};
      @(posedge clk_sys);
      addr_strobe <= 1'b0;
      ad_in <= ~{1'b0, a};
      @(posedge clk_sys);
      data_strobe <= 1'b1;
      read_not_write <= rd;
      chip_select_n <= 1'b0;
      if (!rd) begin
         ad_in <= wd;
      end
      repeat (3) @(posedge clk_sys);
      rd_data = ad_out;
      rd_oe = ad_oe;
      data_strobe <= 1'b0;
      chip_select_n <= 1'b1;
      ad_in <= ~ad_in;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the clock control and status registers.
// Assumes the host model in rtc_host and a 20 MHz system clock.
`timescale 1ns/1ps
module testbench;
   import rtc_pkg::*;
   logic clk_sys = 1'b0;
   logic por_n = 1'b0;
   logic rst_n = 1'b0;
   logic battery_good = 1'b1;
   logic chip_select_n, addr_strobe, data_strobe, read_not_write;
   logic [7:0] ad_in, ad_out;
   logic ad_oe, interrupt_request_n, square_wave_out, count_advance;
   logic user_freeze, binary_format_select, hour_format_select, daylight_saving_enable;
   int err_total = 0;
   int checks_done = 0;
   int n;
   logic sqw_prev;

   always #25 clk_sys = ~clk_sys;

   rtc_host host (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
      .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .read_not_write(read_not_write), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe));

   rtc_control DUT (.clk_sys(clk_sys), .por_n(por_n), .rst_n(rst_n),
      .chip_select_n(chip_select_n), .addr_strobe(addr_strobe),
      .data_strobe(data_strobe), .read_not_write(read_not_write), .ad_in(ad_in),
      .ad_out(ad_out), .ad_oe(ad_oe), .interrupt_request_n(interrupt_request_n),
      .square_wave_out(square_wave_out), .battery_good(battery_good),
      .time_now(rtc_hms_s'(24'h010203)), .alarm_time(rtc_hms_s'(24'h112233)),
      .count_advance(count_advance), .user_freeze(user_freeze),
      .binary_format_select(binary_format_select),
      .hour_format_select(hour_format_select),
      .daylight_saving_enable(daylight_saving_enable));

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.access(1'b0, a, d);
   endtask

   task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
      host.access(1'b1, a, 8'h00);
      chk(what, host.rd_data, exp);
   endtask

   task automatic pin_chk(input string what, input logic exp);
      repeat (2) @(posedge clk_sys);
      chk(what, {7'h00, interrupt_request_n}, {7'h00, exp});
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      por_n <= 1'b1;
      rst_n <= 1'b1;
      rd_chk("validity", ADDR_VALID, 8'h80);
      @(posedge clk_sys) battery_good <= 1'b0;
      rd_chk("validity_low", ADDR_VALID, 8'h00);
      @(posedge clk_sys) battery_good <= 1'b1;
      wr(ADDR_VALID, 8'h00);
      rd_chk("validity_wr", ADDR_VALID, 8'h80);
      wr(ADDR_RATE, 8'ha3);
      rd_chk("rate", ADDR_RATE, 8'h23);
      rd_chk("flags_idle", ADDR_FLAGS, 8'h00);
      wr(ADDR_MODE, 8'h1f);
      rd_chk("mode", ADDR_MODE, 8'h1f);
      chk("mode_pins", {5'h00, binary_format_select, hour_format_select,
         daylight_saving_enable}, 8'h07);
      repeat (3000) @(posedge clk_sys);
      chk("irq_masked", {7'h00, interrupt_request_n}, 8'h01);
      n = 0;
      sqw_prev = square_wave_out;
      for (int i = 0; i < 6000; i++) begin
         @(posedge clk_sys);
         if (square_wave_out !== sqw_prev) begin
            n++;
         end
         sqw_prev = square_wave_out;
      end
      chk("sqw_toggles", {7'h00, n >= 4}, 8'h01);
      wr(ADDR_MODE, 8'h5f);
      pin_chk("irq_late_enable", 1'b0);
      rd_chk("flags_pf", ADDR_FLAGS, 8'hc0);
      pin_chk("irq_after_read", 1'b1);
      @(posedge clk_sys) rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      pin_chk("irq_reset", 1'b1);
      chk("sqw_reset", {7'h00, square_wave_out}, 8'h00);
      rd_chk("mode_reset", ADDR_MODE, 8'h07);
      rd_chk("rate_reset", ADDR_RATE, 8'h23);
      wr(ADDR_MODE, 8'h97);
      rd_chk("mode_freeze", ADDR_MODE, 8'h87);
      chk("freeze_pin", {7'h00, user_freeze}, 8'h01);
      rd_chk("rate_frozen", ADDR_RATE, 8'h23);
      wr(ADDR_FLAGS, 8'hff);
      host.access(1'b1, ADDR_FLAGS, 8'h00);
      chk("flags_low", host.rd_data & 8'h8f, 8'h00);
      host.access(1'b1, 7'h0e, 8'h00);
      chk("unmapped_oe", {7'h00, host.rd_oe}, 8'h00);
      test_done();
   end

   initial begin
      repeat (90000) @(posedge clk_sys);
      err_total++;
      test_done();
   end
endmodule
